// ---- logic/counter_array_mode_config.sv ----
// Function
// - idle suspend set stops the counter while the cpu idles.
// - watchdog enable set raises the watchdog_active output.
// - after reset watchdog enabled; mode register reads with only that bit.
// - enable bit or lock bit either one enables the watchdog.
// - once locked, disabling the watchdog is ignored until reset.
// - timebase select picks clock/12, /4, timer0, ext falls, clock, ext/8.
// - external clock divided by eight is synchronised before counting.
// - overflow flag sets on ffff to 0000 wrap, held until cleared.
// - overflow irq enable gates the flag onto the interrupt request.
// - while watchdog enabled, writes leave other mode bits unchanged.
// - reload bank select steers compare byte accesses to reload regs.
// - reload registers act only in reload-capable pwm modes.
// - unused mode bit 4 reads zero and ignores writes.
`default_nettype none
module counter_array_mode_config #(
  parameter int N_MODULES = 3
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    cpu_idle,
  input  wire logic                    counter_run,
  input  wire logic                    timer0_overflow,
  input  wire logic                    external_count_input,
  input  wire logic                    ext_clk,
  input  wire logic [N_MODULES-1:0]    reload_pwm_mode,
  output logic      [15:0]             counter_value,
  output logic                         counter_overflow_flag,
  output logic                         irq_request,
  output logic                         watchdog_active,
  output logic                         counter_suspended,
  output logic      [16*N_MODULES-1:0] compare_values
);
  if (N_MODULES < 1 || N_MODULES > 4) begin : g_chk
    $error("N_MODULES must be 1 to 4");
  end

  // register fields and internal state
  logic        idle_suspend_q;
  logic        watchdog_enable_bit_q;
  logic        lock_q;
  logic [2:0]  tb_sel_q;
  logic        irq_en_q;
  logic        reload_bank_q;
  logic        ovf_flag_q;
  logic [15:0] counter_q;
  logic [7:0]  rdata_q;
  logic        irq_q;
  logic        wd_active_q;
  logic        suspended_q;
  logic [15:0] cmp_out_q [N_MODULES];
  logic        tick;

  compare_bank_if #(.N_MODULES(N_MODULES)) bank_bus ();

  // address decode
  wire wr_mode   = reg_wr && (reg_addr == counter_array_pkg::OFS_MODE);
  wire wr_pwm    = reg_wr && (reg_addr == counter_array_pkg::OFS_PWM_CFG);
  wire wr_status = reg_wr && (reg_addr == counter_array_pkg::OFS_STATUS);
  wire [7:0] cmp_ofs = reg_addr - counter_array_pkg::OFS_CMP_BASE;
  wire cmp_hit = (reg_addr >= counter_array_pkg::OFS_CMP_BASE) &&
                 (cmp_ofs < 8'(2 * N_MODULES));

  // lock or enable freezes the rest of the mode register
  wire wd_on  = watchdog_enable_bit_q | lock_q;
  wire frozen = wd_on;
  wire wd_bit = reg_wdata[counter_array_pkg::MODE_WATCHDOG_ENABLE_BIT_BIT];
  // locked: a written zero cannot clear the enable
  wire watchdog_enable_bit_d = lock_q ? (watchdog_enable_bit_q | wd_bit) : wd_bit;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      idle_suspend_q <= counter_array_pkg::MODE_RESET[
                          counter_array_pkg::MODE_IDLE_BIT];
      watchdog_enable_bit_q         <= counter_array_pkg::MODE_RESET[
                          counter_array_pkg::MODE_WATCHDOG_ENABLE_BIT_BIT];
      lock_q         <= counter_array_pkg::MODE_RESET[
                          counter_array_pkg::MODE_LOCK_BIT];
      tb_sel_q       <= counter_array_pkg::MODE_RESET[
                          counter_array_pkg::MODE_TB_MSB:
                          counter_array_pkg::MODE_TB_LSB];
      irq_en_q       <= counter_array_pkg::MODE_RESET[
                          counter_array_pkg::MODE_IRQ_EN_BIT];
    end else if (wr_mode) begin
      watchdog_enable_bit_q <= watchdog_enable_bit_d;
      if (!frozen) begin
        idle_suspend_q <= reg_wdata[counter_array_pkg::MODE_IDLE_BIT];
        lock_q         <= reg_wdata[counter_array_pkg::MODE_LOCK_BIT];
        tb_sel_q       <= reg_wdata[counter_array_pkg::MODE_TB_MSB:
                                    counter_array_pkg::MODE_TB_LSB];
        irq_en_q       <= reg_wdata[counter_array_pkg::MODE_IRQ_EN_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reload_bank_q <= counter_array_pkg::PWM_CFG_RESET[
                         counter_array_pkg::PWM_BANK_BIT];
    end else if (wr_pwm) begin
      reload_bank_q <= reg_wdata[counter_array_pkg::PWM_BANK_BIT];
    end
  end

  timebase_gen u_timebase (
    .sys_clk              (sys_clk),
    .resetn               (resetn),
    .tb_sel               (tb_sel_q),
    .timer0_overflow      (timer0_overflow),
    .external_count_input (external_count_input),
    .ext_clk              (ext_clk),
    .tick                 (tick)
  );

  // counter and overflow flag
  wire suspend  = idle_suspend_q & cpu_idle;
  wire count_en = tick & counter_run & ~suspend;
  wire wrap     = count_en && (counter_q == counter_array_pkg::COUNT_MAX);
  wire flag_clr = wr_status &&
                  !reg_wdata[counter_array_pkg::STATUS_OVF_BIT];
  // a wrap in the clearing cycle keeps the flag set
  wire flag_d   = wrap | (ovf_flag_q & ~flag_clr);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      counter_q  <= 16'h0000;
      ovf_flag_q <= counter_array_pkg::STATUS_RESET[
                      counter_array_pkg::STATUS_OVF_BIT];
    end else begin
      if (count_en) begin
        counter_q <= counter_q + 16'h0001;
      end
      ovf_flag_q <= flag_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_q       <= 1'b0;
      wd_active_q <= 1'b0;
      suspended_q <= 1'b0;
    end else begin
      irq_q       <= ovf_flag_q & irq_en_q;
      wd_active_q <= wd_on;
      suspended_q <= suspend;
    end
  end

  // compare bank access
  assign bank_bus.wr_en       = reg_wr && cmp_hit;
  assign bank_bus.idx         = cmp_ofs[2:1];
  assign bank_bus.hi_sel      = cmp_ofs[0];
  assign bank_bus.reload_sel  = reload_bank_q;
  assign bank_bus.wdata       = reg_wdata;
  assign bank_bus.reload_now  = wrap;
  assign bank_bus.reload_mode = reload_pwm_mode;

  compare_bank #(.N_MODULES(N_MODULES)) u_bank (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .bus     (bank_bus)
  );

  // registered copy so the top outputs stay flop-driven
  for (genvar i = 0; i < N_MODULES; i++) begin : g_cmp_out
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        cmp_out_q[i] <= 16'h0000;
      end else begin
        cmp_out_q[i] <= bank_bus.compare_flat[16*i +: 16];
      end
    end
    assign compare_values[16*i +: 16] = cmp_out_q[i];
  end

  // read data mux
  wire [7:0] mode_rd = {idle_suspend_q, watchdog_enable_bit_q, lock_q, 1'b0,
                        tb_sel_q, irq_en_q};
  wire [7:0] pwm_rd  = {reload_bank_q, 7'h00};
  wire [7:0] stat_rd = {ovf_flag_q, 7'h00};
  wire [7:0] rd_mux  =
    (reg_addr == counter_array_pkg::OFS_MODE)     ? mode_rd :
    (reg_addr == counter_array_pkg::OFS_PWM_CFG)  ? pwm_rd :
    (reg_addr == counter_array_pkg::OFS_STATUS)   ? stat_rd :
    (reg_addr == counter_array_pkg::OFS_COUNT_LO) ? counter_q[7:0] :
    (reg_addr == counter_array_pkg::OFS_COUNT_HI) ? counter_q[15:8] :
    cmp_hit                                       ? bank_bus.rdata :
                                                    8'h00;

  // data only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata             = rdata_q;
  assign counter_value         = counter_q;
  assign counter_overflow_flag = ovf_flag_q;
  assign irq_request           = irq_q;
  assign watchdog_active       = wd_active_q;
  assign counter_suspended     = suspended_q;
endmodule
`default_nettype wire

// ---- inc/counter_array_pkg.sv ----
`default_nettype none
package counter_array_pkg;
  localparam int COUNT_WIDTH = 16;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // register offsets
  localparam logic [7:0] OFS_STATUS      = 8'hd8;
  localparam logic [7:0] OFS_MODE        = 8'hd9;
  localparam logic [7:0] OFS_PWM_CFG     = 8'hf7;
  localparam logic [7:0] OFS_COUNT_LO    = 8'he1;
  localparam logic [7:0] OFS_COUNT_HI    = 8'he2;
  localparam logic [7:0] OFS_CMP_BASE    = 8'he8;

  // field positions
  localparam int STATUS_OVF_BIT  = 7;
  localparam int MODE_IDLE_BIT   = 7;
  localparam int MODE_WATCHDOG_ENABLE_BIT_BIT   = 6;
  localparam int MODE_LOCK_BIT   = 5;
  localparam int MODE_TB_LSB     = 1;
  localparam int MODE_TB_MSB     = 3;
  localparam int MODE_IRQ_EN_BIT = 0;
  localparam int PWM_BANK_BIT    = 7;

  // reset values
  localparam logic [7:0] MODE_RESET    = 8'h40;
  localparam logic [7:0] PWM_CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;

  // timebase encodings and divide counts
  typedef enum logic [2:0] {
    TB_DIV12   = 3'h0,
    TB_DIV4    = 3'h1,
    TB_TIMER0  = 3'h2,
    TB_EXT_FALL = 3'h3,
    TB_SYSCLK  = 3'h4,
    TB_EXT_DIV8 = 3'h5
  } timebase_t;

  localparam logic [3:0] DIV12_LAST   = 4'hb;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
endpackage
`default_nettype wire

// ---- inc/compare_bank_if.sv ----
`default_nettype none
interface compare_bank_if #(
  parameter int N_MODULES = 3
);
  logic                    wr_en;
  logic [1:0]              idx;
  logic                    hi_sel;
  logic                    reload_sel;
  logic [7:0]              wdata;
  logic [7:0]              rdata;
  logic                    reload_now;
  logic [N_MODULES-1:0]    reload_mode;
  logic [16*N_MODULES-1:0] compare_flat;

  modport ctrl (
    output wr_en,
    output idx,
    output hi_sel,
    output reload_sel,
    output wdata,
    output reload_now,
    output reload_mode,
    input  rdata,
    input  compare_flat
  );

  modport bank (
    input  wr_en,
    input  idx,
    input  hi_sel,
    input  reload_sel,
    input  wdata,
    input  reload_now,
    input  reload_mode,
    output rdata,
    output compare_flat
  );
endinterface
`default_nettype wire

// ---- logic/timebase_gen.sv ----
`default_nettype none
module timebase_gen (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] tb_sel,
  input  wire logic       timer0_overflow,
  input  wire logic       external_count_input,
  input  wire logic       ext_clk,
  output logic            tick
);
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic       eci_prev_q;
  logic       ext_meta_q;
  logic       ext_sync_q;
  logic       ext_prev_q;
  logic [2:0] ext_cnt_q;
  logic       tick_q;

  wire div12_hit = (div12_q == counter_array_pkg::DIV12_LAST);
  wire div4_hit  = (div4_q == counter_array_pkg::DIV4_LAST);
  // input is synchronous; one stage suffices for the edge
  wire eci_fall  = eci_prev_q & ~external_count_input;
  wire ext_rise  = ext_sync_q & ~ext_prev_q;
  wire ext_hit   = ext_rise & (ext_cnt_q == counter_array_pkg::EXT_DIV_LAST);

  logic tick_d;
  always_comb begin
    unique case (tb_sel)
      counter_array_pkg::TB_DIV12:    tick_d = div12_hit;
      counter_array_pkg::TB_DIV4:     tick_d = div4_hit;
      counter_array_pkg::TB_TIMER0:   tick_d = timer0_overflow;
      counter_array_pkg::TB_EXT_FALL: tick_d = eci_fall;
      counter_array_pkg::TB_SYSCLK:   tick_d = 1'b1;
      counter_array_pkg::TB_EXT_DIV8: tick_d = ext_hit;
      default:                        tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div12_q    <= 4'h0;
      div4_q     <= 2'h0;
      eci_prev_q <= 1'b0;
      tick_q     <= 1'b0;
    end else begin
      div12_q    <= div12_hit ? 4'h0 : div12_q + 4'h1;
      div4_q     <= div4_q + 2'h1;
      eci_prev_q <= external_count_input;
      tick_q     <= tick_d;
    end
  end

  // external clock is asynchronous to sys_clk: two-stage sync
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      ext_cnt_q  <= 3'h0;
    end else begin
      ext_meta_q <= ext_clk;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      if (ext_rise) begin
        ext_cnt_q <= ext_cnt_q + 3'h1;
      end
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// ---- logic/compare_bank.sv ----
`default_nettype none
module compare_bank #(
  parameter int N_MODULES = 3
) (
  input  wire logic     sys_clk,
  input  wire logic     resetn,
  compare_bank_if.bank  bus
);
  logic [15:0] cmp_q [N_MODULES];
  logic [15:0] rel_q [N_MODULES];

  for (genvar i = 0; i < N_MODULES; i++) begin : g_mod
    wire sel    = bus.wr_en && (bus.idx == 2'(i));
    wire wr_cmp = sel && !bus.reload_sel;
    wire wr_rel = sel && bus.reload_sel;
    // reload only for modules in a reload-capable pwm mode
    wire do_rel = bus.reload_now && bus.reload_mode[i];

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        cmp_q[i] <= 16'h0000;
        rel_q[i] <= 16'h0000;
      end else begin
        if (wr_rel && bus.hi_sel) begin
          rel_q[i][15:8] <= bus.wdata;
        end else if (wr_rel) begin
          rel_q[i][7:0] <= bus.wdata;
        end
        // software write beats a same-cycle reload
        if (wr_cmp && bus.hi_sel) begin
          cmp_q[i][15:8] <= bus.wdata;
        end else if (wr_cmp) begin
          cmp_q[i][7:0] <= bus.wdata;
        end else if (do_rel) begin
          cmp_q[i] <= rel_q[i];
        end
      end
    end

    assign bus.compare_flat[16*i +: 16] = cmp_q[i];
  end

  wire [15:0] rd_word = bus.reload_sel ? rel_q[bus.idx] : cmp_q[bus.idx];
  assign bus.rdata = bus.hi_sel ? rd_word[15:8] : rd_word[7:0];
endmodule
`default_nettype wire

// ---- tb/counter_array_mode_config_asserts.sv ----
`default_nettype none
module counter_array_mode_config_asserts (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        cpu_idle,
  input wire logic        counter_run,
  input wire logic [15:0] counter_value,
  input wire logic        counter_overflow_flag,
  input wire logic        irq_request,
  input wire logic        watchdog_active,
  input wire logic        counter_suspended
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_wrap;
    $past(counter_value) == 16'hffff && counter_value == 16'h0000;
  endsequence
  a_flag_on_wrap: assert property (s_wrap |-> counter_overflow_flag)
    else $error("wrap without overflow flag");
  a_flag_sticky: assert property ($past(counter_overflow_flag) &&
    !($past(reg_wr) && $past(reg_addr) == 8'hd8 && !$past(reg_wdata[7]))
    |-> counter_overflow_flag) else $error("overflow flag lost");
  a_irq_cause: assert property (irq_request
    |-> $past(counter_overflow_flag)) else $error("irq without flag");
  a_count_step: assert property (counter_value != $past(counter_value)
    |-> counter_value == $past(counter_value) + 16'h0001)
    else $error("counter jumped");
  a_run_hold: assert property (!$past(counter_run)
    |-> $stable(counter_value)) else $error("counted while stopped");
  a_idle_hold: assert property (counter_suspended
    |-> $stable(counter_value)) else $error("counted while suspended");
  a_wd_reset: assert property ($rose(resetn) |=> watchdog_active)
    else $error("watchdog off after reset");
  a_bit4_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'hd9
    |-> reg_rdata[4] == 1'b0) else $error("mode bit 4 set");
  a_pwm_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'hf7
    |-> reg_rdata[6:0] == 7'h00) else $error("pwm cfg low bits set");
endmodule
bind counter_array_mode_config counter_array_mode_config_asserts u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .counter_run(counter_run),
  .counter_value(counter_value),
  .counter_overflow_flag(counter_overflow_flag),
  .irq_request(irq_request), .watchdog_active(watchdog_active),
  .counter_suspended(counter_suspended)
);
`default_nettype wire

// ---- tb/counter_array_mode_config_bench.sv ----
`default_nettype none
module counter_array_mode_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        cpu_idle = 1'b0, counter_run = 1'b0, timer0_overflow = 1'b0;
  logic        external_count_input = 1'b1, ext_clk = 1'b0;
  logic [2:0]  reload_pwm_mode = 3'h0;
  logic [31:0] cyc = 32'h0000_0000;
  logic [15:0] counter_value;
  logic [47:0] compare_values;
  logic        counter_overflow_flag, irq_request;
  logic        watchdog_active, counter_suspended;
  int          n_errors = 0;
  int          n_tests = 0;
  int          mode_m;
  logic [15:0] cmp_m [3];
  logic [15:0] rld_m [3];
  int          exp_tb [8] = '{8, 24, 16, 12, 96, 3, 0, 0};

  counter_array_mode_config #(.N_MODULES(3)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .counter_run(counter_run),
    .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input), .ext_clk(ext_clk),
    .reload_pwm_mode(reload_pwm_mode), .counter_value(counter_value),
    .counter_overflow_flag(counter_overflow_flag),
    .irq_request(irq_request), .watchdog_active(watchdog_active),
    .counter_suspended(counter_suspended), .compare_values(compare_values)
  );

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // event sources at fixed rates; falls every 8 cycles stay under clock/4
  always @(posedge sys_clk) begin
    cyc <= cyc + 32'h0000_0001;
    timer0_overflow <= (cyc % 6 == 0);
    external_count_input <= cyc[2];
    ext_clk <= cyc[1];
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] e,
                     input string msg);
    n_tests++;
    if (got !== e) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, e);
    end
  endtask
  // prescaler phase is not reset on a select change, so allow one count
  task automatic near(input logic [15:0] got, input int e, input string msg);
    int g;
    g = got;
    n_tests++;
    if ($isunknown(got) || g < e - 1 || g > e + 1) begin
      n_errors++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, msg, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = {8'h00, reg_rdata};
  endtask
  task automatic wm(input logic [7:0] d);
    logic [15:0] r;
    wr(8'hd9, d);
    if (mode_m & 'h60)
      mode_m = (mode_m & 'hbf) | ((mode_m & 'h20) ? (mode_m | d) & 'h40
                                                  : d & 'h40);
    else
      mode_m = d & 'hef;
    rd(8'hd9, r);
    chk(r, mode_m[15:0], "mode");
    chk(16'(watchdog_active), 16'((mode_m & 'h60) != 0), "wd");
  endtask
  task automatic count(input int n, output logic [15:0] d);
    logic [15:0] a;
    a = counter_value;
    repeat (n) @(posedge sys_clk);
    #1 d = counter_value - a;
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    logic [15:0] r;
    int          k;
    k = $urandom(71653);
    mode_m = 'h40;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    counter_run <= 1'b1;
    rd(8'hd9, r);
    chk(r, 16'h0040, "mode reset");
    rd(8'hf7, r);
    chk(r, 16'h0000, "pwm reset");
    chk(16'(watchdog_active), 16'h0001, "wd reset");
    wm(8'h7f);
    wm(8'h00);
    wm(8'h99);
    $display("test mode done");
    for (int c = 0; c < 8; c++) begin
      wm(8'(c << 1));
      count(96, r);
      near(r, exp_tb[c], "timebase");
    end
    $display("test timebase done");
    wm(8'h89);
    @(posedge sys_clk);
    cpu_idle <= 1'b1;
    count(3, r);
    count(20, r);
    chk(r, 16'h0000, "idle stop");
    chk(16'(counter_suspended), 16'h0001, "suspended");
    wm(8'h09);
    count(20, r);
    near(r, 20, "idle run");
    @(posedge sys_clk);
    counter_run <= 1'b0;
    count(3, r);
    count(10, r);
    chk(r, 16'h0000, "run stop");
    rd(8'he1, r);
    chk(r, {8'h00, counter_value[7:0]}, "count lo");
    rd(8'he2, r);
    chk(r, {8'h00, counter_value[15:8]}, "count hi");
    @(posedge sys_clk);
    counter_run <= 1'b1;
    $display("test idle done");
    for (int b = 0; b < 2; b++) begin
      wr(8'hf7, b ? 8'h80 : 8'h00);
      for (int n = 0; n < 3; n++) begin
        r = 16'($urandom);
        if (b) rld_m[n] = r;
        else cmp_m[n] = r;
        wr(8'(8'he8 + 2 * n), r[7:0]);
        wr(8'(8'he9 + 2 * n), r[15:8]);
      end
    end
    rd(8'hea, r);
    chk(r, {8'h00, rld_m[1][7:0]}, "reload read");
    wr(8'hf7, 8'h00);
    rd(8'heb, r);
    chk(r, {8'h00, cmp_m[1][15:8]}, "compare read");
    @(posedge sys_clk);
    reload_pwm_mode <= 3'b101;
    wm(8'h08);
    k = 0;
    while (counter_value !== 16'hffff && k < 70000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k == 70000) begin
      n_errors++;
      $display("[ERR] %0t wrap timeout", $time);
      finish_test;
    end
    count(3, r);
    chk(16'(counter_overflow_flag), 16'h0001, "flag");
    chk(16'(irq_request), 16'h0000, "irq masked");
    for (int n = 0; n < 3; n++)
      chk(compare_values[16*n +: 16], n == 1 ? cmp_m[n] : rld_m[n], "cmp");
    wm(8'h09);
    chk(16'(irq_request), 16'h0001, "irq on");
    wr(8'hd8, 8'h00);
    rd(8'hd8, r);
    chk(r, 16'h0000, "flag clear");
    $display("test overflow done");
    wm(8'h20);
    wm(8'h00);
    wm(8'h40);
    wm(8'h00);
    rd(8'h80, r);
    chk(r, 16'h0000, "unmapped");
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    mode_m = 'h40;
    rd(8'hd9, r);
    chk(r, 16'h0040, "mode reset again");
    $display("test lock done");
    finish_test;
  end
endmodule
`default_nettype wire
